// file: rtl/kwu_map.vh
`ifndef KWU_MAP_VH
`define KWU_MAP_VH

// register indexes; byte address is four times the index
`define KWU_IDX_SECOND_DATA      6'h28
`define KWU_IDX_FIRST_DATA       6'h29
`define KWU_IDX_SECOND_DIR       6'h2a
`define KWU_IDX_FIRST_DIR        6'h2b
`define KWU_IDX_SECOND_WAKE_EN   6'h2c
`define KWU_IDX_FIRST_WAKE_EN    6'h2d
`define KWU_IDX_SECOND_FLAGS     6'h2e
`define KWU_IDX_FIRST_FLAGS      6'h2f
`define KWU_IDX_SECOND_POLARITY  6'h30
`define KWU_IDX_FIRST_POLARITY   6'h31
`define KWU_IDX_STATUS           6'h32

// reset values
`define KWU_RST_DIR              8'h00
`define KWU_RST_WAKE_EN          8'h00
`define KWU_RST_FLAGS            8'h00
`define KWU_RST_POLARITY         8'h00
`define KWU_RST_DATA             8'h00

// status register fields
`define KWU_STAT_IRQ             0
`define KWU_STAT_FILTER_RUN      1

// stop filter oscillator period in clock cycles, and sample points
`define KWU_FILT_PERIOD          12
`define KWU_FILT_SAMPLE0         0
`define KWU_FILT_SAMPLE1         4
`define KWU_FILT_SAMPLE2         8

`endif

// file: rtl/kwu_gpio_ports.v
// Added by the designer: register access over APB.
`timescale 1ns/100ps
`include "kwu_map.vh"

module kwu_gpio_ports #(
	parameter NPIN        = 16,
	parameter FILT_PERIOD = `KWU_FILT_PERIOD
) (
	input  wire            clk,
	input  wire            arst_n,
	input  wire            psel,
	input  wire            penable,
	input  wire            pwrite,
	input  wire [7:0]      paddr,
	input  wire [31:0]     pwdata,
	output reg  [31:0]     prdata,
	output reg             pready,
	output reg             pslverr,
	input  wire            stopMode,
	input  wire            waitMode,
	input  wire [NPIN-1:0] padIn,
	output reg  [NPIN-1:0] padOut,
	output reg  [NPIN-1:0] padOe,
	output reg  [NPIN-1:0] pullUpEn,
	output reg  [NPIN-1:0] pullDownEn,
	output reg             irq,
	output reg             wakeRequest
);

	// low byte is the first port, high byte the second port
	reg  [NPIN-1:0] portData;
	reg  [NPIN-1:0] direction;
	reg  [NPIN-1:0] wakeEnable;
	reg  [NPIN-1:0] wakeFlags;
	reg  [NPIN-1:0] polarity;
	reg  [NPIN-1:0] syncA;
	reg  [NPIN-1:0] syncB;
	reg  [NPIN-1:0] prevLevel;
	reg  [7:0]      filtCnt;
	reg             filtRun;

	wire [5:0]      regIdx;
	wire            addrOk;
	wire            setupPh;
	wire            wrEn;
	wire [7:0]      wb;
	wire [NPIN-1:0] trigLevel;
	wire [NPIN-1:0] runEdge;
	wire [NPIN-1:0] polChange;
	wire [NPIN-1:0] filtSet;
	wire [NPIN-1:0] flagSet;
	wire [NPIN-1:0] flagClr;
	wire [NPIN-1:0] next_flags;
	wire [NPIN-1:0] next_pol;
	wire            samplePt;
	wire            periodEnd;
	wire            anyTrig;
	reg  [7:0]      rdByte;
	reg             rdHit;

	// decoded write strobes, then the vote clear and the qualified wake requests
	wire            wrFirstData;
	wire            wrSecondData;
	wire            wrFirstDir;
	wire            wrSecondDir;
	wire            wrFirstEn;
	wire            wrSecondEn;
	wire            wrFirstFlags;
	wire            wrSecondFlags;
	wire            wrFirstPol;
	wire            wrSecondPol;
	wire            voteClear;
	wire [NPIN-1:0] wakeQual;
	wire            anyQual;

	assign regIdx  = paddr[7:2];
	assign addrOk  = (paddr[1:0] == 2'h0) && rdHit;
	assign setupPh = psel && !penable;
	assign wrEn    = psel && penable && pready && pwrite && !pslverr;
	assign wb      = pwdata[7:0];

	// one write strobe per register except the status register
	assign wrFirstData   = wrEn && (regIdx == `KWU_IDX_FIRST_DATA);
	assign wrSecondData  = wrEn && (regIdx == `KWU_IDX_SECOND_DATA);
	assign wrFirstDir    = wrEn && (regIdx == `KWU_IDX_FIRST_DIR);
	assign wrSecondDir   = wrEn && (regIdx == `KWU_IDX_SECOND_DIR);
	assign wrFirstEn     = wrEn && (regIdx == `KWU_IDX_FIRST_WAKE_EN);
	assign wrSecondEn    = wrEn && (regIdx == `KWU_IDX_SECOND_WAKE_EN);
	assign wrFirstFlags  = wrEn && (regIdx == `KWU_IDX_FIRST_FLAGS);
	assign wrSecondFlags = wrEn && (regIdx == `KWU_IDX_SECOND_FLAGS);
	assign wrFirstPol    = wrEn && (regIdx == `KWU_IDX_FIRST_POLARITY);
	assign wrSecondPol   = wrEn && (regIdx == `KWU_IDX_SECOND_POLARITY);

	// synchronized level at the triggering polarity
	assign trigLevel = ~(syncB ^ polarity);
	// edge works regardless of direction
	assign runEdge   = trigLevel & ~(prevLevel ^ polarity ^ {NPIN{1'b1}})
			   & ~{NPIN{stopMode}};

	assign next_pol[7:0]  = wrFirstPol ? wb : polarity[7:0];
	assign next_pol[15:8] = wrSecondPol ? wb : polarity[15:8];
	// polarity change with pin already at new triggering level
	assign polChange = (next_pol ^ polarity) & ~(syncB ^ next_pol);

	assign anyTrig   = |(trigLevel & wakeEnable);
	assign samplePt  = filtRun && (filtCnt == `KWU_FILT_SAMPLE0 ||
			   filtCnt == `KWU_FILT_SAMPLE1 ||
			   filtCnt == `KWU_FILT_SAMPLE2);
	assign periodEnd = filtRun && (filtCnt == FILT_PERIOD - 1);
	// votes restart outside a running filter period
	assign voteClear = !stopMode || !filtRun || periodEnd;

	genvar i;
	generate
		for (i = 0; i < NPIN; i = i + 1)
		begin : gPin
			// per-pin sample registers of the shared filter
			reg vote0;
			reg vote1;
			reg vote2;

			// three samples per filter period
			always @(posedge clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					vote0 <= 1'b0;
					vote1 <= 1'b0;
					vote2 <= 1'b0;
				end
				else if (voteClear)
				begin
					vote0 <= 1'b0;
					vote1 <= 1'b0;
					vote2 <= 1'b0;
				end
				else if (samplePt)
				begin
					if (filtCnt == `KWU_FILT_SAMPLE0)
						vote0 <= trigLevel[i];
					if (filtCnt == `KWU_FILT_SAMPLE1)
						vote1 <= trigLevel[i];
					if (filtCnt == `KWU_FILT_SAMPLE2)
						vote2 <= trigLevel[i];
				end
			end

			// two of three samples at trigger level
			assign filtSet[i] = periodEnd && wakeEnable[i] &&
				((vote0 && vote1) || (vote0 && vote2) ||
				 (vote1 && vote2));
		end
	endgenerate

	assign flagSet = runEdge | polChange | filtSet;
	assign flagClr[7:0]  = wrFirstFlags ? wb : 8'h00;
	assign flagClr[15:8] = wrSecondFlags ? wb : 8'h00;
	// set wins over write-one clear
	assign next_flags = (wakeFlags & ~flagClr) | flagSet;

	// qualified requests merged to one line
	assign wakeQual = next_flags & wakeEnable;
	assign anyQual  = |wakeQual;

	always @*
	begin
		rdByte = 8'h00;
		rdHit  = 1'b1;
		case (regIdx)
			`KWU_IDX_FIRST_DATA:
				rdByte = (portData[7:0] & direction[7:0]) |
					 (syncB[7:0] & ~direction[7:0]);
			`KWU_IDX_SECOND_DATA:
				rdByte = (portData[15:8] & direction[15:8]) |
					 (syncB[15:8] & ~direction[15:8]);
			`KWU_IDX_FIRST_DIR:       rdByte = direction[7:0];
			`KWU_IDX_SECOND_DIR:      rdByte = direction[15:8];
			`KWU_IDX_FIRST_WAKE_EN:   rdByte = wakeEnable[7:0];
			`KWU_IDX_SECOND_WAKE_EN:  rdByte = wakeEnable[15:8];
			`KWU_IDX_FIRST_FLAGS:     rdByte = wakeFlags[7:0];
			`KWU_IDX_SECOND_FLAGS:    rdByte = wakeFlags[15:8];
			`KWU_IDX_FIRST_POLARITY:  rdByte = polarity[7:0];
			`KWU_IDX_SECOND_POLARITY: rdByte = polarity[15:8];
			`KWU_IDX_STATUS:
			begin
				rdByte[`KWU_STAT_IRQ]        = irq;
				rdByte[`KWU_STAT_FILTER_RUN] = filtRun;
			end
			default:                  rdHit = 1'b0;
		endcase
	end

	// apb slave: answer in the first access cycle
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= setupPh;
			if (setupPh)
			begin
				pslverr <= !addrOk;
				prdata  <= (addrOk && !pwrite) ?
					   {24'h000000, rdByte} : 32'h00000000;
			end
			else
			begin
				pslverr <= 1'b0;
			end
		end
	end

	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			polarity   <= {2{`KWU_RST_POLARITY}};
			wakeFlags  <= {2{`KWU_RST_FLAGS}};
		end
		else
		begin
			wakeFlags <= next_flags;
			polarity  <= next_pol;
		end
	end

	// output latch, seen on the pin only when driven
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			portData <= {2{`KWU_RST_DATA}};
		else
		begin
			if (wrFirstData)
				portData[7:0] <= wb;
			if (wrSecondData)
				portData[15:8] <= wb;
		end
	end

	// pin direction, 1 drives the pin
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			direction <= {2{`KWU_RST_DIR}};
		else
		begin
			if (wrFirstDir)
				direction[7:0] <= wb;
			if (wrSecondDir)
				direction[15:8] <= wb;
		end
	end

	// interrupt enables, open to software at any time
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
			wakeEnable <= {2{`KWU_RST_WAKE_EN}};
		else
		begin
			if (wrFirstEn)
				wakeEnable[7:0] <= wb;
			if (wrSecondEn)
				wakeEnable[15:8] <= wb;
		end
	end

	// pin synchronizer and previous sample
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			syncA     <= {NPIN{1'b0}};
			syncB     <= {NPIN{1'b0}};
			prevLevel <= {NPIN{1'b0}};
		end
		else
		begin
			syncA     <= padIn;
			syncB     <= syncA;
			prevLevel <= syncB;
		end
	end

	// shared stop filter
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			filtRun <= 1'b0;
			filtCnt <= 8'h00;
		end
		else if (!stopMode)
		begin
			filtRun <= 1'b0;
			filtCnt <= 8'h00;
		end
		else if (!filtRun)
		begin
			filtRun <= anyTrig;
			filtCnt <= 8'h00;
		end
		// restart while an enabled pin sits at its trigger level
		else if (periodEnd)
		begin
			filtRun <= anyTrig;
			filtCnt <= 8'h00;
		end
		else
		begin
			filtCnt <= filtCnt + 8'h01;
		end
	end

	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			padOut     <= {NPIN{1'b0}};
			padOe      <= {NPIN{1'b0}};
			pullUpEn   <= {NPIN{1'b0}};
			pullDownEn <= {NPIN{1'b0}};
		end
		else
		begin
			padOut     <= portData;
			padOe      <= direction;
			pullUpEn   <= ~polarity & ~direction;
			pullDownEn <= polarity & ~direction;
		end
	end

	// one shared request line, and the wake request in stop or wait
	always @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irq         <= 1'b0;
			wakeRequest <= 1'b0;
		end
		else
		begin
			irq         <= anyQual;
			// wake out of stop or wait
			wakeRequest <= anyQual & (stopMode | waitMode);
		end
	end

endmodule

// file: rtl/kwu_placeholder_unused.v
`timescale 1ns/100ps

// file: test/kwu_gpio_ports_monitor.sv
`timescale 1ns/100ps
module kwu_gpio_monitor #(parameter NPIN = 16) (
	input wire            clk,
	input wire            arst_n,
	input wire            psel,
	input wire            penable,
	input wire [7:0]      paddr,
	input wire            pready,
	input wire            pslverr,
	input wire            stopMode,
	input wire            waitMode,
	input wire [NPIN-1:0] padOe,
	input wire [NPIN-1:0] pullUpEn,
	input wire [NPIN-1:0] pullDownEn,
	input wire            irq,
	input wire            wakeRequest
);
	default clocking dc @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire setup = psel && !penable;
	wire badIdx = paddr[7:2] < 6'h28 || paddr[7:2] > 6'h32 || paddr[1:0] != 0;
	property p_pull_in;
		$past(arst_n) |-> (pullUpEn | pullDownEn) == ~padOe;
	endproperty
	a_pull_in: assert property (p_pull_in) else $error("no pull");
	property p_pull_one; (pullUpEn & pullDownEn) == 0; endproperty
	a_pull_one: assert property (p_pull_one) else $error("two pulls");
	property p_reset; $rose(arst_n) |-> padOe == 0 && !irq; endproperty
	a_reset: assert property (p_reset) else $error("reset state");
	property p_wake_irq; wakeRequest |-> irq; endproperty
	a_wake_irq: assert property (p_wake_irq) else $error("wake no irq");
	property p_wake_wait; (irq && waitMode) [*2] |-> wakeRequest; endproperty
	a_wake_wait: assert property (p_wake_wait) else $error("wait wake");
	property p_wake_stop; (irq && stopMode) [*2] |-> wakeRequest; endproperty
	a_wake_stop: assert property (p_wake_stop) else $error("stop wake");
	property p_ready; setup |=> pready ##1 !pready; endproperty
	a_ready: assert property (p_ready) else $error("ready timing");
	property p_map; setup |=> pslverr == $past(badIdx); endproperty
	a_map: assert property (p_map) else $error("bad decode");
	c_irq: cover property (irq ##1 !irq);
	c_stop: cover property (stopMode && wakeRequest);
	c_err: cover property (pslverr);
endmodule
bind kwu_gpio_ports kwu_gpio_monitor #(.NPIN(NPIN)) u_mon(.clk, .arst_n,
	.psel, .penable, .paddr, .pready, .pslverr, .stopMode, .waitMode,
	.padOe, .pullUpEn, .pullDownEn, .irq, .wakeRequest);

// file: test/kwu_pad_model.sv
`timescale 1ns/100ps
module kwu_pad_model (
	input wire [15:0]  padOe,
	input wire [15:0]  padOut,
	input wire [15:0]  pullDownEn,
	input wire [15:0]  drvEn,
	input wire [15:0]  drv,
	output wire [15:0] padIn
);
	// undriven input pins settle at their pull level
	assign padIn = padOe & padOut
		| ~padOe & (drvEn & drv | ~drvEn & ~pullDownEn);
endmodule

// file: test/tb.sv
`timescale 1ns/100ps
`define CHK(a,b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
	$display("BAD %0t got %h exp %h", $time, a, b); end end
module tb;
	reg         clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
	reg         stopMode = 0, waitMode = 0;
	reg [7:0]   paddr = 0, rd, bt;
	reg [31:0]  pwdata = 0;
	reg [15:0]  drvEn = 0, drv = 0;
	reg         er;
	wire [31:0] prdata;
	wire        pready, pslverr, irq, wakeRequest;
	wire [15:0] padIn, padOut, padOe, pullUpEn, pullDownEn;
	int         n_fail = 0, n_tests = 0, i, k, s, o, p;
	int         mdl[int];
	always #2.5 clk = ~clk;
	kwu_gpio_ports #(.NPIN(16), .FILT_PERIOD(12)) u_dut(.clk, .arst_n,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .stopMode, .waitMode, .padIn, .padOut, .padOe,
		.pullUpEn, .pullDownEn, .irq, .wakeRequest);
	kwu_pad_model u_pad(.padOe, .padOut, .pullDownEn, .drvEn, .drv, .padIn);
	task automatic apb(input w, input [5:0] a, input [7:0] d);
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= {a, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata[7:0];
		er = pslverr;
		psel <= 0;
		penable <= 0;
		if (w) mdl[a] = d;
	endtask
	task automatic rc(input [5:0] a, input [7:0] e);
		apb(0, a, 0);
		`CHK(rd, e)
	endtask
	task print_verdict;
		$display("tests %0d fails %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		print_verdict;
	end
	initial
	begin
		void'($urandom(32'hbf9b2c4d));
		repeat (12) @(posedge clk);
		arst_n <= 1;
		for (k = 'h2a; k < 'h32; k++) rc(k, 0);
		rc('h32, 0);
		rc('h28, 8'hff);
		rc('h29, 8'hff);
		apb(0, 'h33, 0);
		`CHK(er, 1'b1)
		`CHK(padOe, 16'h0)
		`CHK(pullUpEn, 16'hffff)
		$display("reset test done");
		waitMode <= 1;
		for (i = 0; i < 16; i++)
		begin
			p = $urandom % 2;
			o = i % 2;
			s = i / 8;
			bt = 8'h01 << (i % 8);
			drvEn <= 16'h1 << i;
			drv <= p ? 16'h0 : 16'hffff;
			apb(1, 'h29 - s, p ? 8'h00 : 8'hff);
			for (k = 0; k < 2; k++)
			begin
				apb(1, 'h2b - k, (k == s && o) ? bt : 8'h00);
				apb(1, 'h31 - k, (k == s && p) ? bt : 8'h00);
				apb(1, 'h2d - k, $urandom);
			end
			repeat (6) @(posedge clk);
			apb(1, 'h2e, 8'hff);
			apb(1, 'h2f, 8'hff);
			rc('h2f - s, 0);
			if (o) apb(1, 'h29 - s, p ? 8'hff : 8'h00);
			else drv <= p ? 16'hffff : 16'h0;
			repeat (6) @(posedge clk);
			rc('h2f - s, bt);
			rc('h2d - s, mdl['h2d - s]);
			`CHK(irq, mdl['h2d - s][i % 8])
			`CHK(wakeRequest, mdl['h2d - s][i % 8])
			`CHK(padOe, o ? 16'h1 << i : 16'h0)
			`CHK(pullDownEn, (p && !o) ? 16'h1 << i : 16'h0)
			`CHK(padOut[i], o ? p[0] : !p[0])
			apb(1, 'h2f - s, bt);
			rc('h2f - s, 0);
		end
		$display("edge test done");
		waitMode <= 0;
		stopMode <= 1;
		drvEn <= 16'h3;
		drv <= 16'h3;
		apb(1, 'h31, 0);
		apb(1, 'h2d, 8'h01);
		apb(1, 'h2c, 8'h00);
		apb(1, 'h2e, 8'hff);
		apb(1, 'h2f, 8'hff);
		rc('h2f, 0);
		drv <= 16'h0;
		repeat (2) @(posedge clk);
		drv <= 16'h3;
		repeat (30) @(posedge clk);
		rc('h2f, 0);
		`CHK(wakeRequest, 1'b0)
		drv <= 16'h0;
		repeat (30) @(posedge clk);
		rc('h2f, 8'h01);
		`CHK(wakeRequest, 1'b1)
		stopMode <= 0;
		$display("stop test done");
		print_verdict;
	end
endmodule
